//--- rtl/energy_pulse_calibration_scaler.sv
// active energy gain, divider, pulse output and line-cycle accumulation
`include "epcs_map.svh"
module energy_pulse_calibration_scaler #(
   parameter int RATIO_W = 12,
   parameter int HALFCYC_W = 16
) (
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire logic signed [23:0] ACTIVE_POWER_I,
   input wire logic POWER_VALID_I,
   input wire logic ZERO_CROSS_I,
   input wire logic CFG_WE_I,
   input wire logic signed [11:0] ACTIVE_POWER_GAIN_I,
   input wire logic [RATIO_W-1:0] PULSE_RATIO_NUMER_I,
   input wire logic [RATIO_W-1:0] PULSE_RATIO_DENOM_I,
   input wire logic [7:0] ACTIVE_ENERGY_DIVIDER_I,
   input wire logic [HALFCYC_W-1:0] HALF_CYCLE_COUNT_SETTING_I,
   input wire logic CYCLE_END_MASK_I,
   input wire logic FLAG_CLEAR_I,
   output logic CAL_PULSE_O,
   output logic signed [23:0] ACTIVE_ENERGY_ACCUM_O,
   output logic signed [23:0] LINE_ACTIVE_ENERGY_ACCUM_O,
   output logic [15:0] LINE_PERIOD_O,
   output logic CYCLE_END_FLAG_O,
   output logic IRQ_N_O,
   output logic IRQ_OE_O
);
   typedef struct packed {
      logic zx_meta;
      logic zx_sync;
      logic zx_prev;
      logic signed [11:0] gain;
      logic [RATIO_W-1:0] numer;
      logic [RATIO_W-1:0] denom;
      logic [7:0] divider;
      logic [HALFCYC_W-1:0] halfset;
      logic mask;
      logic signed [47:0] e_acc;
      logic signed [47:0] line_acc;
      logic signed [23:0] line_out;
      logic [2:0] pre8;
      logic [15:0] per_cnt;
      logic [15:0] period;
      logic [HALFCYC_W-1:0] half_cnt;
      logic flag;
      logic irq_oe;
      logic pulse_q;
      logic signed [23:0] energy_out;
      epcs_pkg::div_state_t dv_st;
      logic [5:0] dv_idx;
      logic [47:0] dv_num;
      logic [8:0] dv_rem;
      logic [47:0] dv_quo;
      logic dv_neg;
      logic [7:0] dv_den;
   } st_t;
   st_t st_ff, nxt_st;

   pulse_if pif ();

   // one plus gain over 4096, applied once and shared by both paths
   function automatic epcs_pkg::power_t gain_scale(input logic signed [23:0] p, input logic signed [11:0] g);
      logic signed [35:0] prod;
      prod = 36'(p) * 36'(g);
      gain_scale = 26'(p) + 26'(prod >>> `EPCS_GAIN_SHIFT);
   endfunction

   epcs_pkg::power_t scaled;
   logic zx_edge;
   logic zx_rise;
   logic [8:0] dv_trial;
   logic cyc_end;

   assign scaled = gain_scale(ACTIVE_POWER_I, st_ff.gain);
   assign pif.power = scaled;
   assign pif.valid = POWER_VALID_I;
   assign pif.numer = epcs_pkg::ratio_t'(st_ff.numer);
   assign pif.denom = epcs_pkg::ratio_t'(st_ff.denom);

   pulse_rate_gen u_pulse (
      .clk_i(CLK_I),
      .srst_i(SRST_I),
      .pif(pif)
   );

   always_comb begin
      nxt_st = st_ff;
      zx_edge = st_ff.zx_sync ^ st_ff.zx_prev;
      zx_rise = st_ff.zx_sync & ~st_ff.zx_prev;
      dv_trial = {st_ff.dv_rem[7:0], st_ff.dv_num[47]};
      cyc_end = 1'b0;
      nxt_st.zx_meta = ZERO_CROSS_I;
      nxt_st.zx_sync = st_ff.zx_meta;
      nxt_st.zx_prev = st_ff.zx_sync;
      nxt_st.pulse_q = pif.pulse;
      if (CFG_WE_I) begin
         nxt_st.gain = ACTIVE_POWER_GAIN_I;
         nxt_st.numer = PULSE_RATIO_NUMER_I;
         nxt_st.denom = PULSE_RATIO_DENOM_I;
         nxt_st.divider = ACTIVE_ENERGY_DIVIDER_I;
         nxt_st.halfset = HALF_CYCLE_COUNT_SETTING_I;
         nxt_st.mask = CYCLE_END_MASK_I;
      end
      if (POWER_VALID_I) begin
         nxt_st.e_acc = st_ff.e_acc + 48'(scaled);
         nxt_st.line_acc = st_ff.line_acc + 48'(scaled);
      end
      // period in units of eight clocks, rising edge to rising edge
      nxt_st.pre8 = st_ff.pre8 + 3'h1;
      if (zx_rise) begin
         nxt_st.period = st_ff.per_cnt;
         nxt_st.per_cnt = 16'h0;
         nxt_st.pre8 = 3'h0;
      end else if (st_ff.pre8 == 3'(`EPCS_PERIOD_UNIT - 1) && st_ff.per_cnt != 16'hffff) begin
         nxt_st.per_cnt = st_ff.per_cnt + 16'h1;
      end
      // both edges of the crossing mark a half cycle; a zero setting idles
      if (zx_edge && st_ff.halfset != '0) begin
         if (st_ff.half_cnt + 1'b1 >= st_ff.halfset) begin
            nxt_st.half_cnt = '0;
            nxt_st.line_out = nxt_st.line_acc[47:24];
            nxt_st.line_acc = 48'h0;
            nxt_st.flag = 1'b1;
            cyc_end = 1'b1;
         end else begin
            nxt_st.half_cnt = st_ff.half_cnt + 1'b1;
         end
      end
      // set beats clear in the same cycle
      // a set flag being set again must still beat the clear
      if (FLAG_CLEAR_I && !cyc_end) begin
         nxt_st.flag = 1'b0;
      end
      nxt_st.irq_oe = nxt_st.flag & nxt_st.mask;
      // serial divide keeps the pulse path free of the divider
      unique case (st_ff.dv_st)
         epcs_pkg::DV_IDLE: begin
            nxt_st.dv_neg = st_ff.e_acc[47];
            nxt_st.dv_num = st_ff.e_acc[47] ? 48'(-st_ff.e_acc) : st_ff.e_acc;
            nxt_st.dv_den = (st_ff.divider == 8'h00) ? 8'h01 : st_ff.divider;
            nxt_st.dv_rem = 9'h0;
            nxt_st.dv_quo = 48'h0;
            nxt_st.dv_idx = 6'h0;
            nxt_st.dv_st = epcs_pkg::DV_RUN;
         end
         epcs_pkg::DV_RUN: begin
            nxt_st.dv_num = {st_ff.dv_num[46:0], 1'b0};
            if (dv_trial >= {1'b0, st_ff.dv_den}) begin
               nxt_st.dv_rem = dv_trial - {1'b0, st_ff.dv_den};
               nxt_st.dv_quo = {st_ff.dv_quo[46:0], 1'b1};
            end else begin
               nxt_st.dv_rem = dv_trial;
               nxt_st.dv_quo = {st_ff.dv_quo[46:0], 1'b0};
            end
            nxt_st.dv_idx = st_ff.dv_idx + 6'h1;
            if (st_ff.dv_idx == 6'd47) begin
               nxt_st.energy_out = st_ff.dv_neg ? 24'(-nxt_st.dv_quo[47:24]) : nxt_st.dv_quo[47:24];
               nxt_st.dv_st = epcs_pkg::DV_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         st_ff <= '0;
         st_ff.numer <= RATIO_W'(`EPCS_RATIO_RESET);
         st_ff.denom <= RATIO_W'(`EPCS_RATIO_RESET);
         st_ff.divider <= `EPCS_DIVIDER_RESET;
         st_ff.halfset <= HALFCYC_W'(`EPCS_HALFCYC_RESET);
         st_ff.dv_st <= epcs_pkg::DV_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign CAL_PULSE_O = st_ff.pulse_q;
   assign ACTIVE_ENERGY_ACCUM_O = st_ff.energy_out;
   assign LINE_ACTIVE_ENERGY_ACCUM_O = st_ff.line_out;
   assign LINE_PERIOD_O = st_ff.period;
   assign CYCLE_END_FLAG_O = st_ff.flag;
   assign IRQ_N_O = 1'b0;
   assign IRQ_OE_O = st_ff.irq_oe;
endmodule

//--- rtl/epcs_map.svh
// constants of the energy pulse calibration scaler
`ifndef EPCS_MAP_SVH
`define EPCS_MAP_SVH
`define EPCS_CLK_HZ 200000000
`define EPCS_SAMPLE_DIV 4
`define EPCS_CF_MAX_HZ 23000
`define EPCS_FS_POWER 4194304
`define EPCS_GAIN_SHIFT 12
`define EPCS_PERIOD_UNIT 8
`define EPCS_RATIO_RESET 12'h03f
`define EPCS_DIVIDER_RESET 8'h00
`define EPCS_HALFCYC_RESET 16'hffff
`define EPCS_ENERGY_LSB_POS 24
`endif

//--- rtl/epcs_pkg.sv
// types shared by the energy pulse calibration scaler
package epcs_pkg;
   typedef logic signed [25:0] power_t;
   typedef logic [11:0] ratio_t;
   typedef enum logic [1:0] {
      DV_IDLE = 2'b01,
      DV_RUN = 2'b10
   } div_state_t;
endpackage

//--- rtl/pulse_if.sv
// carrier between the energy path and the pulse rate generator
interface pulse_if;
   epcs_pkg::power_t power;
   logic valid;
   epcs_pkg::ratio_t numer;
   epcs_pkg::ratio_t denom;
   logic pulse;
   modport gen (input power, input valid, input numer, input denom, output pulse);
   modport user (output power, output valid, output numer, output denom, input pulse);
endinterface

//--- rtl/pulse_rate_gen.sv
// calibration pulse generator driven by gain-scaled active power
`include "epcs_map.svh"
module pulse_rate_gen (
   input wire logic clk_i,
   input wire logic srst_i,
   pulse_if.gen pif
);
   localparam longint SAMPLE_HZ = `EPCS_CLK_HZ / `EPCS_SAMPLE_DIV;
   // full-scale power at ratio one crosses this once per 1/23kHz
   localparam logic signed [63:0] BASE = 64'(longint'(`EPCS_FS_POWER) * SAMPLE_HZ / `EPCS_CF_MAX_HZ);

   typedef struct packed {
      logic signed [63:0] acc;
      logic pulse;
   } st_t;
   st_t st_ff, nxt_st;

   logic signed [63:0] thresh;
   logic signed [63:0] step;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.pulse = 1'b0;
      thresh = BASE * $signed({52'h0, pif.denom} + 64'h1);
      step = 64'(pif.power) * $signed({52'h0, pif.numer} + 64'h1);
      if (pif.valid) begin
         nxt_st.acc = st_ff.acc + step;
      end
      // either sign of energy emits a pulse; reverse flow is still metered
      if (nxt_st.acc >= thresh) begin
         nxt_st.acc = nxt_st.acc - thresh;
         nxt_st.pulse = 1'b1;
      end else if (nxt_st.acc <= -thresh) begin
         nxt_st.acc = nxt_st.acc + thresh;
         nxt_st.pulse = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pif.pulse = st_ff.pulse;
endmodule

//--- dv/epcs_assertions.sv
// port-level assertions for the energy pulse calibration scaler
module epcs_assertions (
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire logic POWER_VALID_I,
   input wire logic CFG_WE_I,
   input wire logic CYCLE_END_MASK_I,
   input wire logic FLAG_CLEAR_I,
   input wire logic CAL_PULSE_O,
   input wire logic signed [23:0] LINE_ACTIVE_ENERGY_ACCUM_O,
   input wire logic CYCLE_END_FLAG_O,
   input wire logic IRQ_N_O,
   input wire logic IRQ_OE_O
);
   logic mask_ff;
   // shadow of the loaded mask, since the mask itself is not a port
   always_ff @(posedge CLK_I) begin
      if (SRST_I) mask_ff <= 1'b0;
      else if (CFG_WE_I) mask_ff <= CYCLE_END_MASK_I;
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (SRST_I);
   sequence quiet_s; !POWER_VALID_I [*4]; endsequence
   sequence one_s; CAL_PULSE_O ##1 !CAL_PULSE_O; endsequence
   reset_clear_a: assert property ($fell(SRST_I) |-> !CAL_PULSE_O && !CYCLE_END_FLAG_O && !IRQ_OE_O)
      else $error("output set after reset");
   pulse_width_a: assert property (CAL_PULSE_O |-> one_s)
      else $error("pulse longer than one cycle");
   pulse_cause_a: assert property (CAL_PULSE_O |-> $past(POWER_VALID_I, 2) || $past(POWER_VALID_I, 3))
      else $error("pulse without sample");
   pulse_quiet_a: assert property (quiet_s |=> !CAL_PULSE_O)
      else $error("pulse with no samples");
   flag_hold_a: assert property ($fell(CYCLE_END_FLAG_O) |-> $past(FLAG_CLEAR_I) || $past(SRST_I))
      else $error("flag dropped without clear");
   line_latch_a: assert property ($changed(LINE_ACTIVE_ENERGY_ACCUM_O) |-> CYCLE_END_FLAG_O)
      else $error("line energy moved without cycle end");
   irq_follow_a: assert property (mask_ff == $past(mask_ff) |-> IRQ_OE_O == (CYCLE_END_FLAG_O && mask_ff))
      else $error("interrupt enable wrong");
   irq_level_a: assert property (IRQ_N_O == 1'b0)
      else $error("interrupt pin data not low");
endmodule
bind energy_pulse_calibration_scaler epcs_assertions u_epcs_assertions (.*);

//--- dv/line_source.sv
// zero crossing source standing in for the mains line
module line_source #(parameter int HALF_CLK = 400) (
   input wire logic clk_i,
   input wire logic en_i,
   output logic zc_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt = 0;
   initial zc_o = 1'b0;
   // level holds while the line is off
   always @(posedge clk_i) begin
      if (en_i) cnt++;
      if (cnt == HALF_CLK) begin
         cnt = 0;
         zc_o <= #1 ~zc_o;
      end
   end
endmodule

//--- dv/tb_top.sv
// self-checking bench for the energy pulse calibration scaler
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int P = 4194304;
   typedef struct {logic ld; int p; int g; int n; int d; int dv; int ns;} row_t;
   row_t r;
   // ratios kept at or below one pulse per sample, the most a one-cycle pulse can carry
   row_t rows[7] = '{'{1,P,0,63,63,0,2000}, '{1,P,0,63,127,0,2000}, '{1,P,2047,63,63,0,2000},
      '{1,P,-2048,63,63,0,2000}, '{1,P,0,63,63,255,2000}, '{1,-P,0,63,63,0,2000}, '{0,2*P-1,0,63,63,0,4400}};
   logic clk = 0, srst = 1, vld = 0, we = 0, msk = 0, fclr = 0, run = 0, lon = 0;
   logic signed [23:0] pwr = '0, ae, lae;
   logic signed [11:0] g = '0;
   logic [11:0] n = '0, d = '0;
   logic [7:0] dv = '0;
   logic [15:0] hc = '0, per;
   logic zc, cal, flag, irqn, irqoe;
   int err_total = 0, checks_done = 0, pulses = 0, ph = 0, t;
   real s, base = 4194304.0 * 50.0e6 / 23000.0;
   line_source u_line_source (.clk_i(clk), .en_i(lon), .zc_o(zc));
   energy_pulse_calibration_scaler u_energy_pulse_calibration_scaler (.CLK_I(clk), .SRST_I(srst),
      .ACTIVE_POWER_I(pwr), .POWER_VALID_I(vld), .ZERO_CROSS_I(zc), .CFG_WE_I(we), .ACTIVE_POWER_GAIN_I(g),
      .PULSE_RATIO_NUMER_I(n), .PULSE_RATIO_DENOM_I(d), .ACTIVE_ENERGY_DIVIDER_I(dv),
      .HALF_CYCLE_COUNT_SETTING_I(hc), .CYCLE_END_MASK_I(msk), .FLAG_CLEAR_I(fclr), .CAL_PULSE_O(cal),
      .ACTIVE_ENERGY_ACCUM_O(ae), .LINE_ACTIVE_ENERGY_ACCUM_O(lae), .LINE_PERIOD_O(per),
      .CYCLE_END_FLAG_O(flag), .IRQ_N_O(irqn), .IRQ_OE_O(irqoe));
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      if (cal === 1'b1) pulses++;
      ph = (ph + 1) % 4;
      vld <= #1 run && ph == 0;
   end
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string w, input int e, input logic signed [31:0] v, input int tol);
      checks_done++;
      if ($isunknown(v) || v < e - tol || v > e + tol) begin
         err_total++;
         $display("BAD %s expected %0d seen %0d", w, e, v);
      end
   endtask
   task automatic cfg(input int gg, nn, dd, ddv, hh, input logic mm);
      {g, n, d, dv, hc, msk} = {gg[11:0], nn[11:0], dd[11:0], ddv[7:0], hh[15:0], mm};
      we = 1;
      cyc(1);
      we = 0;
   endtask
   task automatic rst(input int k);
      srst = 1;
      cyc(k);
      srst = 0;
   endtask
   // clears the sticky flag, then counts cycles until it is set again
   task automatic wt();
      fclr = 1;
      cyc(1);
      fclr = 0;
      t = 0;
      while (flag !== 1'b1 && t < 9000) begin
         cyc(1);
         t++;
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      rst(16);
      chk("reset energy", 0, ae, 0);
      foreach (rows[i]) begin
         r = rows[i];
         rst(2);
         if (r.ld) cfg(r.g, r.n, r.d, r.dv, 0, 0);
         pwr = r.p[23:0];
         pulses = 0;
         run = 1;
         cyc(4 * r.ns);
         run = 0;
         cyc(120);
         s = real'(r.ns) * r.p * (1.0 + r.g / 4096.0);
         chk("pulses", $rtoi((s < 0 ? -s : s) * (r.n + 1) / (base * (r.d + 1))), pulses, 1);
         chk("energy", $rtoi(s / (r.dv == 0 ? 1 : r.dv) / 16777216.0), ae, 1);
      end
      rst(2);
      cfg(0, 63, 63, 0, 3, 1);
      pwr = 24'h400000;
      run = 1;
      lon = 1;
      wt();
      wt();
      chk("interval", 1199, t, 4);
      chk("irq enable", 1, irqoe, 0);
      chk("period", 100, per, 1);
      chk("line energy", 75, lae, 1);
      cfg(0, 63, 63, 0, 3, 0);
      wt();
      chk("flag set", 1, flag, 0);
      chk("irq masked", 0, irqoe, 0);
      final_report();
   end
   initial begin
      repeat (90000) @(posedge clk);
      err_total++;
      final_report();
   end
endmodule
